// ===== verilog/dcache_front.sv
// Load-pair access front end of a banked data cache, with prefetch hold,
// write combining and code/data line exclusion.
// Assumes core-side requests are synchronous to I_CORE_CLK.
`timescale 1ns/1ps
`default_nettype none
module dcache_front
    import dcache_front_pkg::*;
(
    input  wire logic                         I_CORE_CLK,
    input  wire logic                         I_RST_N,
    input  wire logic                         I_LD0_VALID,
    input  wire dcache_front_pkg::addr_t      I_LD0_ADDR,
    input  wire logic                         I_LD1_VALID,
    input  wire dcache_front_pkg::addr_t      I_LD1_ADDR,
    output logic                              O_LD0_TAKE,
    output logic                              O_LD1_TAKE,
    output logic                              O_LD0_DONE,
    output logic [dcache_front_pkg::DATA_W-1:0] O_LD0_DATA,
    output logic                              O_LD1_DONE,
    output logic [dcache_front_pkg::DATA_W-1:0] O_LD1_DATA,
    output logic                              O_CONFLICT,
    input  wire logic                         I_ST_VALID,
    input  wire dcache_front_pkg::addr_t      I_ST_ADDR,
    input  wire logic [dcache_front_pkg::DATA_W-1:0] I_ST_DATA,
    input  wire logic [dcache_front_pkg::SIZE_W-1:0] I_ST_SIZE,
    input  wire logic                         I_ST_PENDING,
    input  wire dcache_front_pkg::addr_t      I_ST_PEND_ADDR,
    input  wire logic                         I_PF_VALID,
    input  wire dcache_front_pkg::addr_t      I_PF_ADDR,
    output logic                              O_PF_TAKE,
    output logic                              O_PF_ISSUE,
    output dcache_front_pkg::addr_t           O_PF_ADDR,
    input  wire logic                         I_WC_VALID,
    input  wire dcache_front_pkg::addr_t      I_WC_ADDR,
    input  wire logic [dcache_front_pkg::DATA_W-1:0] I_WC_DATA,
    input  wire logic [dcache_front_pkg::SIZE_W-1:0] I_WC_SIZE,
    output logic                              O_WC_FLUSH,
    output dcache_front_pkg::line_t           O_WC_LINE,
    output logic [dcache_front_pkg::LINE_W-1:0] O_WC_DATA,
    output logic [dcache_front_pkg::LINE_BYTES-1:0] O_WC_BE,
    input  wire logic                         I_IC_FILL,
    input  wire dcache_front_pkg::addr_t      I_IC_ADDR,
    output logic                              O_IC_INVAL,
    output dcache_front_pkg::line_t           O_IC_INVAL_LINE,
    output logic                              O_DC_CASTOUT,
    output dcache_front_pkg::line_t           O_DC_CASTOUT_LINE
);
    import dcache_front_pkg::*;

    localparam int ROWS = 1 << ROW_W;

    function automatic logic [BANK_W-1:0] bank_of(input addr_t a);
        return a[ROW_LSB-1:BANK_LSB];
    endfunction
    function automatic logic [ROW_W-1:0] row_of(input addr_t a);
        return a[ROW_LSB+ROW_W-1:ROW_LSB];
    endfunction
    function automatic line_t line_of(input addr_t a);
        return a[ADDR_W-1:LINE_LSB];
    endfunction
    function automatic logic [LINE_BYTES-1:0] be_of(input addr_t a,
                                                  input logic [SIZE_W-1:0] s);
        logic [LINE_BYTES-1:0] m;
        m = '0;
        for (int i = 0; i < BANK_BYTES; i++) begin
            if (i < int'(s)) begin
                m[int'(a[LINE_LSB-1:0]) + i] = 1'b1;
            end
        end
        return m;
    endfunction

    // Storage: one array per bank, 16 bytes per entry
    logic [DATA_W-1:0] bank_mem [NUM_BANKS][ROWS];

    logic conflict;
    always_comb begin
        conflict = I_LD0_VALID && I_LD1_VALID
                && bank_of(I_LD0_ADDR) == bank_of(I_LD1_ADDR)
                && row_of(I_LD0_ADDR) != row_of(I_LD1_ADDR);
    end

    // Older load always goes; younger only if it pairs cleanly
    logic take0;
    logic take1;
    assign take0 = I_LD0_VALID;
    assign take1 = I_LD0_VALID && I_LD1_VALID && !conflict;

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_LD0_TAKE <= 1'b0;
            O_LD1_TAKE <= 1'b0;
            O_LD0_DONE <= 1'b0;
            O_LD1_DONE <= 1'b0;
            O_LD0_DATA <= '0;
            O_LD1_DATA <= '0;
            O_CONFLICT <= 1'b0;
        end else begin
            O_LD0_TAKE <= take0;
            O_LD1_TAKE <= take1;
            O_LD0_DONE <= take0;
            O_LD1_DONE <= take1;
            O_LD0_DATA <= bank_mem[bank_of(I_LD0_ADDR)][row_of(I_LD0_ADDR)];
            O_LD1_DATA <= bank_mem[bank_of(I_LD1_ADDR)][row_of(I_LD1_ADDR)];
            O_CONFLICT <= conflict;
        end
    end

    // Store write into the banks
    always_ff @(posedge I_CORE_CLK) begin
        if (I_ST_VALID) begin
            bank_mem[bank_of(I_ST_ADDR)][row_of(I_ST_ADDR)] <= I_ST_DATA;
        end
    end

    // Prefetch hold: a prefetch matching a pending store waits
    logic  pf_held_q;
    addr_t pf_addr_q;
    logic  pf_match;
    logic  st_done_match;
    assign pf_match = I_ST_PENDING
                   && line_of(I_PF_ADDR) == line_of(I_ST_PEND_ADDR);
    assign st_done_match = I_ST_VALID
                   && line_of(I_ST_ADDR) == line_of(pf_addr_q);

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pf_held_q  <= 1'b0;
            pf_addr_q  <= '0;
            O_PF_TAKE  <= 1'b0;
            O_PF_ISSUE <= 1'b0;
            O_PF_ADDR  <= '0;
        end else begin
            O_PF_TAKE  <= I_PF_VALID && !pf_held_q;
            O_PF_ISSUE <= 1'b0;
            if (pf_held_q) begin
                if (st_done_match) begin
                    pf_held_q  <= 1'b0;
                    O_PF_ISSUE <= 1'b1;
                    O_PF_ADDR  <= pf_addr_q;
                end
            end else if (I_PF_VALID) begin
                if (pf_match) begin
                    pf_held_q <= 1'b1;
                    pf_addr_q <= I_PF_ADDR;
                end else begin
                    O_PF_ISSUE <= 1'b1;
                    O_PF_ADDR  <= I_PF_ADDR;
                end
            end
        end
    end

    // Write combining buffer, one aligned line
    logic                  wc_open_q;
    line_t                 wc_line_q;
    logic [LINE_W-1:0]     wc_data_q;
    logic [LINE_BYTES-1:0] wc_be_q;
    logic                  wc_hit;
    logic [LINE_BYTES-1:0] wc_new_be;
    assign wc_hit    = wc_open_q && line_of(I_WC_ADDR) == wc_line_q;
    assign wc_new_be = be_of(I_WC_ADDR, I_WC_SIZE);

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            wc_open_q  <= 1'b0;
            wc_line_q  <= '0;
            wc_data_q  <= '0;
            wc_be_q    <= '0;
            O_WC_FLUSH <= 1'b0;
            O_WC_LINE  <= '0;
            O_WC_DATA  <= '0;
            O_WC_BE    <= '0;
        end else begin
            O_WC_FLUSH <= 1'b0;
            if (I_WC_VALID) begin
                if (wc_open_q && !wc_hit) begin
                    O_WC_FLUSH <= 1'b1;
                    O_WC_LINE  <= wc_line_q;
                    O_WC_DATA  <= wc_data_q;
                    O_WC_BE    <= wc_be_q;
                end
                for (int b = 0; b < LINE_BYTES; b++) begin
                    if (wc_new_be[b]) begin
                        wc_data_q[b*8 +: 8] <= I_WC_DATA[
                            (b - int'(I_WC_ADDR[LINE_LSB-1:0]))*8 +: 8];
                    end
                end
                wc_be_q   <= wc_hit ? (wc_be_q | wc_new_be) : wc_new_be;
                wc_line_q <= line_of(I_WC_ADDR);
                wc_open_q <= 1'b1;
            end
        end
    end

    // Code/data exclusion: track one line last claimed by each side; a store in the same cycle drops an IC fill
    logic  dc_owned_q;
    line_t dc_line_q;
    logic  ic_owned_q;
    line_t ic_line_q;

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            dc_owned_q        <= 1'b0;
            dc_line_q         <= '0;
            ic_owned_q        <= 1'b0;
            ic_line_q         <= '0;
            O_IC_INVAL        <= 1'b0;
            O_IC_INVAL_LINE   <= '0;
            O_DC_CASTOUT      <= 1'b0;
            O_DC_CASTOUT_LINE <= '0;
        end else begin
            O_IC_INVAL   <= 1'b0;
            O_DC_CASTOUT <= 1'b0;
            if (I_ST_VALID) begin
                dc_owned_q <= 1'b1;
                dc_line_q  <= line_of(I_ST_ADDR);
                if (ic_owned_q && ic_line_q == line_of(I_ST_ADDR)) begin
                    O_IC_INVAL      <= 1'b1;
                    O_IC_INVAL_LINE <= ic_line_q;
                    ic_owned_q      <= 1'b0;
                end
            end else if (I_IC_FILL) begin
                ic_owned_q <= 1'b1;
                ic_line_q  <= line_of(I_IC_ADDR);
                if (dc_owned_q && dc_line_q == line_of(I_IC_ADDR)) begin
                    O_DC_CASTOUT      <= 1'b1;
                    O_DC_CASTOUT_LINE <= dc_line_q;
                    dc_owned_q        <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== verilog/dcache_front_pkg.sv
// Constants and types for the load-pair data cache front end.
// Assumes a single core clock; no software-visible registers.
// Summary of operation
// - Sixteen banks, each a 16-byte slice.
// - Conflict only same bank, different row.
// - Two loads without conflict, else one.
// - Loads served strictly in program order.
// - Hold matching prefetch until store written.
// - Merge writes within one aligned line.
// - Line of 64 bytes is the unit.
// - Cast line out of other cache.
package dcache_front_pkg;
    localparam int ADDR_W      = 32;
    localparam int NUM_BANKS   = 16;
    localparam int BANK_BYTES  = 16;
    localparam int LINE_BYTES  = 64;
    localparam int BANK_LSB    = 4;
    localparam int BANK_W      = 4;
    localparam int ROW_LSB     = BANK_LSB + BANK_W;
    localparam int ROW_W       = 6;
    localparam int LINE_LSB    = 6;
    localparam int DATA_W      = BANK_BYTES * 8;
    localparam int LINE_W      = LINE_BYTES * 8;
    localparam int SIZE_W      = 5;
    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [ADDR_W-LINE_LSB-1:0] line_t;
endpackage

// ===== verification/dcache_front_props.sv
// Port assertions for the data cache front end.
// Assumes binding to dcache_front; one clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module dcache_front_props
    import dcache_front_pkg::*;
(
    input wire logic  I_CORE_CLK, I_RST_N, I_LD0_VALID, I_LD1_VALID,
    input wire logic  O_LD0_TAKE, O_LD1_TAKE, O_CONFLICT, I_ST_VALID,
    input wire logic  I_ST_PENDING, O_PF_ISSUE, I_WC_VALID, O_WC_FLUSH,
    input wire logic  I_IC_FILL, O_IC_INVAL, O_LD0_DONE, O_LD1_DONE,
    input wire addr_t I_LD0_ADDR, I_LD1_ADDR, I_ST_ADDR, I_ST_PEND_ADDR,
    input wire addr_t O_PF_ADDR, I_WC_ADDR, I_IC_ADDR,
    input wire line_t O_WC_LINE
);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);
    wire logic pair = I_LD0_VALID && I_LD1_VALID;
    wire logic clash = I_LD0_ADDR[7:4] == I_LD1_ADDR[7:4]
                    && I_LD0_ADDR[13:8] != I_LD1_ADDR[13:8];
    // Line on I_WC_ADDR in the previous cycle, sampled whether or not I_WC_VALID was set
    line_t wc_prev_q;
    always_ff @(posedge I_CORE_CLK) begin
        wc_prev_q <= I_WC_ADDR[31:6];
    end
    wire logic wc_same = I_WC_ADDR[31:6] == wc_prev_q;
    property p_take; I_LD0_VALID |=> O_LD0_TAKE; endproperty
    a_take: assert property (p_take) else $error("load lost");
    property p_cfl; pair && clash |=> O_CONFLICT && !O_LD1_TAKE; endproperty
    a_cfl: assert property (p_cfl) else $error("clash missed");
    property p_dual; pair && !clash |=> O_LD1_TAKE && !O_CONFLICT; endproperty
    a_dual: assert property (p_dual) else $error("pair split");
    property p_done; I_LD0_VALID |=> O_LD0_DONE
        && O_LD1_DONE == $past(pair && !clash); endproperty
    a_done: assert property (p_done) else $error("load not done");
    property p_ord; O_LD1_TAKE |-> O_LD0_TAKE; endproperty
    a_ord: assert property (p_ord) else $error("younger alone");
    property p_pf; O_PF_ISSUE && $past(I_ST_PENDING)
        && $past(I_ST_PEND_ADDR[31:6]) == O_PF_ADDR[31:6]
        |-> $past(I_ST_VALID) && $past(I_ST_ADDR[31:6]) == O_PF_ADDR[31:6];
    endproperty
    a_pf: assert property (p_pf) else $error("early prefetch");
    property p_wc; I_WC_VALID ##1 (I_WC_VALID && !wc_same)
        |=> O_WC_FLUSH && O_WC_LINE == $past(I_WC_ADDR[31:6], 2); endproperty
    a_wc: assert property (p_wc) else $error("no flush");
    property p_wcm; I_WC_VALID ##1 (I_WC_VALID && wc_same) |=> !O_WC_FLUSH;
    endproperty
    a_wcm: assert property (p_wcm) else $error("line split");
    property p_ic; (I_IC_FILL && !I_ST_VALID) ##1 (I_ST_VALID && !I_IC_FILL
        && I_ST_ADDR[31:6] == $past(I_IC_ADDR[31:6])) |-> ##[1:2] O_IC_INVAL;
    endproperty
    a_ic: assert property (p_ic) else $error("code kept");
endmodule
bind dcache_front dcache_front_props props_u (.*);
`default_nettype wire

// ===== verification/core_lsu_model.sv
// Core load issue model: two oldest loads at a time, in program order.
// Assumes the take answer is settled one edge after presentation.
`timescale 1ns/1ps
`default_nettype none
module core_lsu_model
    import dcache_front_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_take0,
    input  wire logic i_take1,
    output logic      o_v0,
    output logic      o_v1,
    output addr_t     o_a0,
    output addr_t     o_a1
);
    addr_t q[$];
    int    n_pair = 0;
    int    n_one = 0;
    task automatic push(input addr_t a);
        q.push_back(a);
    endtask
    initial begin
        {o_v0, o_v1, o_a0, o_a1} = '0;
        forever begin
            @(posedge i_clk);
            #1;
            if (q.size() > 0) begin
                o_a0 = q[0];
                o_v0 = 1'b1;
                o_v1 = q.size() > 1;
                if (o_v1) o_a1 = q[1];
                @(posedge i_clk);
                #1;
                {o_v0, o_v1} = 2'b00;
                o_a0 = ~o_a0;
                o_a1 = ~o_a1;
                // Refused younger load comes back as the older one
                if (i_take0 === 1'b1) void'(q.pop_front());
                if (i_take1 === 1'b1) begin
                    void'(q.pop_front());
                    n_pair++;
                end else n_one++;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verification/dcache_front_tb.sv
// Testbench for the data cache front end.
// Assumes the core model drives loads; the bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
module dcache_front_tb;
    import dcache_front_pkg::*;
    logic clk = 0;
    logic rst_n = 0;
    logic v0, v1, t0, t1, cfl, sv, sp, pv, pi, wv, wf, icf, ici, dco;
    addr_t a0, a1, sa, spa, pa, wa, ica;
    logic [DATA_W-1:0] sd;
    logic [SIZE_W-1:0] ss, ws;
    line_t wl, fl;
    logic [LINE_BYTES-1:0] wbe, fbe;
    logic d0, d1, pt;
    logic [DATA_W-1:0] r0, r1;
    addr_t pfa;
    line_t il, cl;
    logic [LINE_W-1:0] wd, fd;
    localparam logic [63:0] WC_WORD = 64'h0123_4567_89AB_CDEF;
    localparam logic [DATA_W-1:0] LD_WORD =
        128'h0123_4567_89AB_CDEF_0011_2233_4455_6677;
    int n_errors = 0;
    int comparisons = 0;
    bit hit;
    always #2 clk = ~clk;
    always @(posedge clk) if (wf) begin
        fl <= wl;
        fbe <= wbe;
        fd <= wd;
    end
    core_lsu_model lsu_u (.i_clk(clk), .i_take0(t0), .i_take1(t1),
        .o_v0(v0), .o_v1(v1), .o_a0(a0), .o_a1(a1));
    dcache_front dut_u (.I_CORE_CLK(clk), .I_RST_N(rst_n),
        .I_LD0_VALID(v0), .I_LD0_ADDR(a0), .I_LD1_VALID(v1),
        .I_LD1_ADDR(a1), .O_LD0_TAKE(t0), .O_LD1_TAKE(t1), .O_LD0_DONE(d0),
        .O_LD0_DATA(r0), .O_LD1_DONE(d1), .O_LD1_DATA(r1), .O_CONFLICT(cfl),
        .I_ST_VALID(sv), .I_ST_ADDR(sa), .I_ST_DATA(sd), .I_ST_SIZE(ss),
        .I_ST_PENDING(sp), .I_ST_PEND_ADDR(spa), .I_PF_VALID(pv),
        .I_PF_ADDR(pa), .O_PF_TAKE(pt), .O_PF_ISSUE(pi), .O_PF_ADDR(pfa),
        .I_WC_VALID(wv), .I_WC_ADDR(wa), .I_WC_DATA(sd), .I_WC_SIZE(ws),
        .O_WC_FLUSH(wf), .O_WC_LINE(wl), .O_WC_DATA(wd), .O_WC_BE(wbe),
        .I_IC_FILL(icf), .I_IC_ADDR(ica), .O_IC_INVAL(ici),
        .O_IC_INVAL_LINE(il), .O_DC_CASTOUT(dco), .O_DC_CASTOUT_LINE(cl));
    task automatic check(input bit ok, input string msg);
        comparisons++;
        if (!ok) begin
            n_errors++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic watch(ref logic s, input int n, output bit h);
        h = s === 1'b1;
        repeat (n) begin
            tick();
            h |= s === 1'b1;
        end
    endtask
    task automatic t_loads;
        addr_t l[6] = '{32'h100, 32'h110, 32'h200, 32'h300, 32'h308,
                        32'h400};
        foreach (l[i]) lsu_u.push(l[i]);
        for (int i = 0; i < 40 && lsu_u.q.size() > 0; i++) tick();
        check(lsu_u.n_pair == 2 && lsu_u.n_one == 2, "pairing");
    endtask
    task automatic t_data;
        sv = 1'b1;
        sa = 32'h100;
        sd = LD_WORD;
        tick();
        sa = 32'h110;
        sd = ~LD_WORD;
        tick();
        sv = 1'b0;
        lsu_u.push(32'h100);
        lsu_u.push(32'h110);
        for (int i = 0; i < 8 && d0 !== 1'b1; i++) tick();
        check(d1 === 1'b1 && r0 === LD_WORD, "older load data");
        check(r1 === ~LD_WORD, "younger load data");
        for (int i = 0; i < 8 && lsu_u.q.size() > 0; i++) tick();
    endtask
    task automatic t_pf;
        sp = 1'b1;
        spa = 32'h1000;
        pv = 1'b1;
        pa = 32'h1010;
        tick();
        pv = 1'b0;
        check(pt === 1'b1, "prefetch not taken");
        watch(pi, 6, hit);
        check(!hit, "prefetch not held");
        pv = 1'b1;
        pa = 32'h2000;
        tick();
        pv = 1'b0;
        check(pt === 1'b0 && pi === 1'b0, "held twice");
        sv = 1'b1;
        sa = 32'h1000;
        tick();
        {sv, sp} = 2'b00;
        watch(pi, 2, hit);
        check(hit && pfa === 32'h1010, "prefetch not released");
    endtask
    task automatic t_wc;
        sd = {64'h0, WC_WORD};
        wv = 1'b1;
        wa = 32'h40;
        tick();
        wa = 32'h48;
        tick();
        wa = 32'h80;
        ws = 5'h04;
        tick();
        wv = 1'b0;
        repeat (2) tick();
        check(fl === 26'h1 && fbe === 64'hFFFF, "bad flush");
        check(fd[127:0] === {2{WC_WORD}}, "flush data");
    endtask
    task automatic t_coh;
        icf = 1'b1;
        ica = 32'h3000;
        tick();
        {icf, sv} = 2'b01;
        sa = 32'h3008;
        tick();
        sv = 1'b0;
        watch(ici, 2, hit);
        check(hit, "code line kept");
        check(il === 26'hC0, "code line number");
        sv = 1'b1;
        sa = 32'h5000;
        tick();
        {icf, sv} = 2'b10;
        ica = 32'h5000;
        tick();
        icf = 1'b0;
        watch(dco, 2, hit);
        check(hit, "data line kept");
        check(cl === 26'h140, "data line number");
    endtask
    task automatic results;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        {sv, sp, pv, wv, icf, sa, spa, pa, wa, ica, sd} = '0;
        ss = 5'h10;
        ws = 5'h08;
        repeat (8) tick();
        rst_n = 1'b1;
        t_loads();
        t_data();
        t_pf();
        t_wc();
        t_coh();
        results();
    end
    initial begin
        #4000;
        n_errors++;
        results();
    end
endmodule
`default_nettype wire
